// [design/lpm_ctrl.sv]
// Low power mode controller with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.

// Gate enables are registered and follow the power state by one edge.
// Reads load the word at the address phase; a peripheral enable write
// still in its data phase is forwarded, so a back-to-back enable read is fresh.
// Mode requests are taken only while running; both bits mean power-down.
// The wake pin passes four flops before it may end idle or power-down.
// Leaving power-down holds every core clock for the full settle count.
// Helper logic near the end only feeds the assertions.
`timescale 1ns/10ps
`default_nettype none
module lpm_ctrl #(
  parameter int NUM_PERIPH = 32,
  parameter int SETTLE_CYC = lpm_pkg::OSC_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Wake sources
  input  wire logic [NUM_PERIPH-1:0] periph_irq,
  input  wire logic                  async_wake,
  // Clock gate controls
  output logic                       cpu_clk_en,
  output logic                       bus_clk_en,
  output logic                       mem_clk_en,
  output logic                       osc_en,
  output logic                       pin_hold,
  output logic [NUM_PERIPH-1:0]      periph_clk_en
);
  // Refuse parameter values the logic cannot serve
  if (NUM_PERIPH < 1 || NUM_PERIPH > 32) begin : g_bad_periph
    $error("NUM_PERIPH must be 1 to 32");
  end
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
    $error("SETTLE_CYC out of range");
  end

  // Registers
  logic [1:0]             mode_req;            // Idle and power-down requests
  logic [NUM_PERIPH-1:0]  peripheral_power_enables;
  lpm_pkg::lpm_state_t    state;               // Power state
  logic [15:0]            settle_cnt;          // Oscillator settle counter
  logic [2:0]             wake_sync;           // Three-stage wake synchroniser
  logic                   wake_seen;           // Agreed wake level
  // Helper logic for assertions
  logic [15:0]            wake_age;            // Cycles spent settling
  // Next gate pattern
  lpm_pkg::lpm_gates_t    next_gates;          // Gate enables to register
  // Bus data phase capture
  logic                   dp_write;
  logic                   dp_valid;
  logic [7:0]             dp_addr;
  lpm_pkg::lpm_ahb_req_t  req;

  // Bundle the address phase
  assign req = '{hsel, haddr, htrans, hwrite, hsize, hready};

  // Address phase acceptance
  wire addr_take = req.hsel && req.hready && req.htrans[1];
  // Byte offset match on the low address bits
  function automatic logic addr_hits(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  // Register word for an address phase, zero when unmapped
  function automatic logic [31:0] read_word(
    input logic [7:0]  addr,
    input logic [31:0] mode_w,
    input logic [31:0] pen_w,
    input logic [31:0] stat_w
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    if (addr_hits(addr, lpm_pkg::OFF_MODE_CTRL)) begin
      word = mode_w;
    end else if (addr_hits(addr, lpm_pkg::OFF_PERIPH_EN)) begin
      word = pen_w;
    end else if (addr_hits(addr, lpm_pkg::OFF_STATUS)) begin
      word = stat_w;
    end
    return word;
  endfunction

  // Decodes on the data phase address
  wire sel_mode  = addr_hits(dp_addr, lpm_pkg::OFF_MODE_CTRL);
  wire sel_pen   = addr_hits(dp_addr, lpm_pkg::OFF_PERIPH_EN);
  wire wr_mode   = dp_valid && dp_write && sel_mode;
  wire wr_pen    = dp_valid && dp_write && sel_pen;
  // Any enabled peripheral interrupt wakes idle
  wire irq_wake  = |(periph_irq & peripheral_power_enables);
  // Synchronised clockless wake from power-down
  wire pd_wake   = wake_seen;
  // Slave always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Peripheral enables as they stand after this cycle's write
  wire [NUM_PERIPH-1:0] next_pen = wr_pen ? hwdata[NUM_PERIPH-1:0] : peripheral_power_enables;
  // Read words; a peripheral enable write in its data phase is forwarded to a following read
  wire [31:0] rd_mode = {30'h0000_0000, mode_req};
  wire [31:0] rd_pen  = 32'(next_pen);
  wire [31:0] rd_stat = {30'h0000_0000, state};
  wire [31:0] rd_word = read_word(haddr[7:0], rd_mode, rd_pen, rd_stat);

  // Data phase capture
  always_ff @(posedge clk) begin
    if (rst) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (hready) begin
      dp_valid <= addr_take;
      dp_write <= hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  // Read data register, loaded at the address phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // Peripheral enable register
  always_ff @(posedge clk) begin
    if (rst) begin
      peripheral_power_enables <= lpm_pkg::RST_PERIPH_EN[NUM_PERIPH-1:0];
    end else if (wr_pen) begin
      peripheral_power_enables <= hwdata[NUM_PERIPH-1:0];
    end
  end

  // Wake pin synchroniser; second and third must agree
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_sync <= 3'h0;
      wake_seen <= 1'b0;
    end else begin
      wake_sync <= {wake_sync[1:0], async_wake};
      if (wake_sync[1] == wake_sync[2]) begin
        wake_seen <= wake_sync[2];
      end
    end
  end

  // Power state machine; hardware wake clears requests, which wins over a write
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= lpm_pkg::LPM_RUN;
      mode_req   <= lpm_pkg::RST_MODE;
      settle_cnt <= 16'h0000;
    end else begin
      unique case (state)
        lpm_pkg::LPM_RUN: begin
          if (wr_mode) begin
            mode_req <= hwdata[1:0];
          end
          if (mode_req[lpm_pkg::BIT_PDOWN]) begin
            state <= lpm_pkg::LPM_PDOWN;
          end else if (mode_req[lpm_pkg::BIT_IDLE]) begin
            state <= lpm_pkg::LPM_IDLE;
          end
        end
        lpm_pkg::LPM_IDLE: begin
          if (irq_wake || pd_wake) begin
            state    <= lpm_pkg::LPM_RUN;
            mode_req <= 2'h0;
          end
        end
        lpm_pkg::LPM_PDOWN: begin
          if (pd_wake) begin
            state      <= lpm_pkg::LPM_WAKE;
            mode_req   <= 2'h0;
            settle_cnt <= 16'(SETTLE_CYC);
          end
        end
        lpm_pkg::LPM_WAKE: begin
          if (settle_cnt == 16'h0001) begin
            state <= lpm_pkg::LPM_RUN;
          end
          settle_cnt <= settle_cnt - 16'h0001;
        end
      endcase
    end
  end

  // Helper counter of settle cycles, watched by the assertions below
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_age <= 16'h0000;
    end else if (state == lpm_pkg::LPM_WAKE) begin
      wake_age <= wake_age + 16'h0001;
    end else begin
      wake_age <= 16'h0000;
    end
  end

  // Clock gating outputs from state
  wire in_idle  = state == lpm_pkg::LPM_IDLE;
  wire in_pd    = state == lpm_pkg::LPM_PDOWN;
  wire in_wake  = state == lpm_pkg::LPM_WAKE;
  wire core_on  = !(in_idle || in_pd || in_wake);
  // Gate pattern per state: idle keeps the oscillator, power-down stops it
  assign next_gates = '{cpu_clk_en: core_on,
                        bus_clk_en: core_on,
                        mem_clk_en: core_on,
                        osc_en:     !in_pd,
                        pin_hold:   in_pd || in_wake};
  // Registered gate enables, one edge behind the state
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_clk_en    <= 1'b1;
      bus_clk_en    <= 1'b1;
      mem_clk_en    <= 1'b1;
      osc_en        <= 1'b1;
      pin_hold      <= 1'b0;
      periph_clk_en <= lpm_pkg::RST_PERIPH_EN[NUM_PERIPH-1:0];
    end else begin
      cpu_clk_en    <= next_gates.cpu_clk_en;
      bus_clk_en    <= next_gates.bus_clk_en;
      mem_clk_en    <= next_gates.mem_clk_en;
      osc_en        <= next_gates.osc_en;
      pin_hold      <= next_gates.pin_hold;
      // Peripherals keep their clock in idle, none in power-down
      periph_clk_en <= (in_pd || in_wake) ? '0 : peripheral_power_enables;
    end
  end

  // Assertions
  sequence s_pd_wake;
    state == lpm_pkg::LPM_PDOWN && pd_wake;
  endsequence
  sequence s_settling;
    state == lpm_pkg::LPM_WAKE && wake_age != 16'(SETTLE_CYC - 1);
  endsequence
  sequence s_settle_done;
    state == lpm_pkg::LPM_WAKE && wake_age == 16'(SETTLE_CYC - 1);
  endsequence
  AST_IDLE_GATES: assert property (@(posedge clk) disable iff (rst)
    state == lpm_pkg::LPM_IDLE |=> !cpu_clk_en && !bus_clk_en && !mem_clk_en)
    else $error("Idle did not gate core clocks");
  AST_PD_OSC: assert property (@(posedge clk) disable iff (rst)
    state == lpm_pkg::LPM_PDOWN |=> !osc_en && periph_clk_en == '0)
    else $error("Power-down left clocks running");
  AST_PD_PINS: assert property (@(posedge clk) disable iff (rst)
    state == lpm_pkg::LPM_PDOWN |=> pin_hold)
    else $error("Pins not held in power-down");
  AST_IDLE_PERIPH: assert property (@(posedge clk) disable iff (rst)
    state == lpm_pkg::LPM_IDLE |=> periph_clk_en == $past(peripheral_power_enables))
    else $error("Peripheral clocks lost in idle");
  AST_IDLE_EXIT: assert property (@(posedge clk) disable iff (rst)
    state == lpm_pkg::LPM_IDLE && irq_wake |=> state == lpm_pkg::LPM_RUN && mode_req == 2'h0)
    else $error("Idle did not exit on interrupt");
  AST_PD_EXIT: assert property (@(posedge clk) disable iff (rst)
    s_pd_wake |=> state == lpm_pkg::LPM_WAKE)
    else $error("Power-down did not exit on wake");
  AST_WAKE_HOLD: assert property (@(posedge clk) disable iff (rst)
    s_settling |=> state == lpm_pkg::LPM_WAKE && !cpu_clk_en)
    else $error("Settle ended early");
  AST_WAKE_DONE: assert property (@(posedge clk) disable iff (rst)
    s_settle_done |=> state == lpm_pkg::LPM_RUN)
    else $error("Settle did not end on time");
  AST_IDLE_STAY: assert property (@(posedge clk) disable iff (rst)
    state == lpm_pkg::LPM_IDLE && !irq_wake && !pd_wake |=> state == lpm_pkg::LPM_IDLE)
    else $error("Idle left without a wake");
  AST_SETTLE: assert property (@(posedge clk) disable iff (rst)
    s_pd_wake |=> !core_on [*1] ##1 (settle_cnt == 16'(SETTLE_CYC) - 16'h0001))
    else $error("Clocks released before settle");
  AST_ENTER_IDLE: assert property (@(posedge clk) disable iff (rst)
    state == lpm_pkg::LPM_RUN && mode_req == 2'h1 |=> state == lpm_pkg::LPM_IDLE)
    else $error("Idle not entered");
  AST_ENTER_PD: assert property (@(posedge clk) disable iff (rst)
    state == lpm_pkg::LPM_RUN && mode_req[1] |=> state == lpm_pkg::LPM_PDOWN)
    else $error("Power-down not entered");
  AST_PEN_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_pen |=> peripheral_power_enables == $past(hwdata[NUM_PERIPH-1:0]))
    else $error("Peripheral enables not written");
endmodule : lpm_ctrl
`default_nettype wire

// [design/lpm_pkg.sv]
// Package for the low power mode controller: offsets, fields, reset values, types
package lpm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MODE_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PERIPH_EN   = 8'h04;
  localparam logic [7:0] OFF_STATUS      = 8'h08;
  // Mode control bit positions
  localparam int         BIT_IDLE        = 0;
  localparam int         BIT_PDOWN       = 1;
  // Reset values
  localparam logic [31:0] RST_PERIPH_EN  = 32'hFFFF_FFFF;
  localparam logic [1:0]  RST_MODE       = 2'h0;
  // Oscillator settle time in ns and cycles at 20 MHz
  localparam int          OSC_SETTLE_NS  = 1000;
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Power states
  typedef enum logic [1:0] {
    LPM_RUN,
    LPM_IDLE,
    LPM_PDOWN,
    LPM_WAKE
  } lpm_state_t;
  // AHB request bundle
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } lpm_ahb_req_t;
  // Clock gate enables
  typedef struct packed {
    logic cpu_clk_en;
    logic bus_clk_en;
    logic mem_clk_en;
    logic osc_en;
    logic pin_hold;
  } lpm_gates_t;
endpackage : lpm_pkg

// [test/lpm_wake_src.sv]
// Interrupt and wake pin sources that face the controller
`timescale 1ns/10ps
`default_nettype none
module lpm_wake_src (
  // Clock
  input  wire logic        clk,
  // Requests from the bench
  input  wire logic [31:0] irq_req,
  input  wire logic        wake_req,
  // Lines into the controller
  output logic      [31:0] periph_irq,
  output logic             async_wake
);
  // Peripheral interrupts are levels in the same clock domain
  always @(posedge clk) begin
    periph_irq <= irq_req;
  end
  // Wake pin changes off the clock edge, needing no clock to be seen
  assign #17 async_wake = wake_req;
endmodule // lpm_wake_src
`default_nettype wire

// [test/test_low_power_mode_controller.sv]
// Self-checking bench for the low power mode controller
`timescale 1ns/10ps
`default_nettype none
module test_low_power_mode_controller;
  localparam int SET = 2;      // Shortened oscillator settle count
  logic        clk, rst, hsel, hwrite, wake_req, hreadyout, hresp, async_wake;
  logic        cpu_clk_en, bus_clk_en, mem_clk_en, osc_en, pin_hold;
  logic [31:0] haddr, hwdata, hrdata, irq_req, periph_irq, periph_clk_en, rnd, rd, en;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          fail_count, cmp_count, k;
  // Design under test, bus ready looped back
  lpm_ctrl #(.NUM_PERIPH(32), .SETTLE_CYC(SET)) lpm_ctrl_inst (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .periph_irq(periph_irq), .async_wake(async_wake),
    .cpu_clk_en(cpu_clk_en), .bus_clk_en(bus_clk_en), .mem_clk_en(mem_clk_en),
    .osc_en(osc_en), .pin_hold(pin_hold), .periph_clk_en(periph_clk_en));
  // Wake sources
  lpm_wake_src lpm_wake_src_inst (.clk(clk), .irq_req(irq_req), .wake_req(wake_req),
    .periph_irq(periph_irq), .async_wake(async_wake));
  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Xorshift source
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction
  // Word compare
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Gate vector compare: cpu, bus, mem, osc, hold
  task automatic chk_gates(input logic [4:0] exp);
    chk_word({27'h0, cpu_clk_en, bus_clk_en, mem_clk_en, osc_en, pin_hold}, {27'h0, exp});
  endtask
  // Expected gate pattern for a state: 0 run, 1 idle, 2 power-down
  function automatic logic [4:0] gates_for(input int mode);
    return (mode == 0) ? 5'b11110 : (mode == 1) ? 5'b00010 : 5'b00001;
  endfunction
  // Verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One AHB-Lite single transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // Flush write, then mode request
  task automatic enter(input logic [31:0] m);
    bus(1'b1, 8'h10, 32'h0000_0000, rd);
    bus(1'b1, lpm_pkg::OFF_MODE_CTRL, m, rd);
    repeat (3) @(posedge clk);
  endtask
  // Wait for cpu clock, counting cycles with oscillator on
  task automatic wake_wait();
    k = 0;
    repeat (40) begin
      @(posedge clk);
      if (cpu_clk_en === 1'b1) break;
      if (osc_en === 1'b1) k++;
    end
  endtask
  // Watchdog
  initial begin
    #(50 * 4000);
    fail_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    {rst, hsel, hwrite, wake_req, htrans, haddr, hwdata, irq_req} = '0;
    rst = 1'b1;
    hsize = 3'b010;
    rnd = 32'h93a6_ad8e;
    fail_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_gates(5'b11110);
    chk_word(periph_clk_en, 32'hFFFF_FFFF);
    bus(1'b0, lpm_pkg::OFF_PERIPH_EN, 32'h0, rd);
    chk_word(rd, lpm_pkg::RST_PERIPH_EN);
    bus(1'b0, 8'h0C, 32'h0, rd);
    chk_word(rd, 32'h0000_0000);
    chk_word({30'h0000_0000, hreadyout, hresp}, 32'h0000_0002);
    // Random enables, then all off
    for (int i = 0; i < 5; i++) begin
      en = (i == 4) ? 32'h0000_0000 : xs();
      bus(1'b1, lpm_pkg::OFF_PERIPH_EN, en, rd);
      bus(1'b0, lpm_pkg::OFF_PERIPH_EN, 32'h0, rd);
      chk_word(rd, en);
      chk_word(periph_clk_en, en);
    end
    // Idle: disabled interrupt ignored, enabled one wakes
    en = (xs() | 32'h0000_0001) & 32'h7FFF_FFFF;
    bus(1'b1, lpm_pkg::OFF_PERIPH_EN, en, rd);
    enter(32'h0000_0001);
    chk_gates(5'b00010);
    chk_word(periph_clk_en, en);
    bus(1'b0, lpm_pkg::OFF_STATUS, 32'h0, rd);
    chk_word(rd, 32'h0000_0001);
    irq_req <= ~en;
    repeat (5) @(posedge clk);
    chk_gates(5'b00010);
    irq_req <= 32'h0000_0001;
    wake_wait();
    irq_req <= 32'h0000_0000;
    chk_gates(5'b11110);
    bus(1'b0, lpm_pkg::OFF_MODE_CTRL, 32'h0, rd);
    chk_word(rd, 32'h0000_0000);
    // Power-down, alone and with both bits set
    for (int m = 2; m < 4; m++) begin
      enter(m);
      chk_gates(5'b00001);
      chk_word(periph_clk_en, 32'h0000_0000);
      bus(1'b0, lpm_pkg::OFF_STATUS, 32'h0, rd);
      chk_word(rd, 32'h0000_0002);
      irq_req <= 32'h0000_0001;
      repeat (6) @(posedge clk);
      irq_req <= 32'h0000_0000;
      chk_gates(5'b00001);
      wake_req <= 1'b1;
      wake_wait();
      wake_req <= 1'b0;
      chk_gates(5'b11110);
      chk_word({31'h0, k >= SET}, 32'h0000_0001);
      bus(1'b0, lpm_pkg::OFF_PERIPH_EN, 32'h0, rd);
      chk_word(rd, en);
      bus(1'b0, lpm_pkg::OFF_MODE_CTRL, 32'h0, rd);
      chk_word(rd, 32'h0000_0000);
      repeat (4) @(posedge clk);
    end
    // Reset also ends power-down and restores defaults
    enter(32'h0000_0002);
    chk_gates(gates_for(2));
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_gates(gates_for(0));
    bus(1'b0, lpm_pkg::OFF_PERIPH_EN, 32'h0, rd);
    chk_word(rd, lpm_pkg::RST_PERIPH_EN);
    bus(1'b0, lpm_pkg::OFF_MODE_CTRL, 32'h0, rd);
    chk_word(rd, 32'h0000_0000);
    report_and_stop();
  end
endmodule // test_low_power_mode_controller
`default_nettype wire
